/* File: hw/pusc_pkg.sv */
// Package: constants, field positions and decode helpers of the power-up strap block
`default_nettype none
package pusc_pkg;

  // Clock and timing
  localparam int CLK_MHZ      = 250;
  localparam int TICK_US      = 1;
  localparam int TICK_CYCLES  = CLK_MHZ * TICK_US;
  localparam int HOLD_MS      = 55;
  localparam int HOLD_TICKS   = (HOLD_MS * 1000) / TICK_US;

  // Register map
  localparam logic [7:0] REF_CFG_OFF  = 8'h0a;
  localparam logic [7:0] REF_CFG_RST  = 8'h00;
  localparam int         REF_DIFF_BIT = 0;

  // Strap pin positions on the gpio bus
  localparam int GPIO_W    = 7;
  localparam int MSEL_LSB  = 0;
  localparam int OCLK0_BIT = 2;
  localparam int AUX_LSB   = 3;
  localparam int OCLK1_BIT = 6;

  // Master clock select codes
  localparam logic [1:0] MSEL_20M  = 2'h2;
  localparam logic [1:0] MSEL_24M  = 2'h3;
  localparam logic [1:0] MSEL_RST  = 2'h0;

  // Frequencies in kHz
  localparam int         KHZ_W       = 17;
  localparam logic [16:0] MCLK_20_KHZ = 17'h04e20;
  localparam logic [16:0] MCLK_24_KHZ = 17'h06000;
  localparam logic [16:0] OCLK0_KHZ   = 17'h061a8;
  localparam logic [16:0] OCLK1_KHZ   = 17'h1e848;

  // Output enable defaults before straps are read
  localparam logic OCLK0_EN_RST = 1'b0;
  localparam logic OCLK1_EN_RST = 1'b1;

  // Master clock frequency for a select code; reserved codes give zero
  function automatic logic [16:0] pusc_mclk_khz(input logic [1:0] code);
    unique case (code)
      MSEL_20M: pusc_mclk_khz = MCLK_20_KHZ;
      MSEL_24M: pusc_mclk_khz = MCLK_24_KHZ;
      default:  pusc_mclk_khz = 17'h00000;
    endcase
  endfunction

endpackage
`default_nettype wire

/* File: hw/pusc_seq_if.sv */
// Interface: strap sequencing signals between the top, sequencer and tick divider
`default_nettype none
interface pusc_seq_if;
  logic sample;
  logic holding;
  logic tick_en;
  logic tick;

  modport seq (output sample, output holding, output tick_en, input tick);
  modport tmr (input tick_en, output tick);
  modport top (input sample, input holding);
endinterface
`default_nettype wire

/* File: hw/pusc_tick.sv */
// Divider that issues a one-cycle microsecond tick while enabled
`default_nettype none
module pusc_tick
  import pusc_pkg::*;
#(
  parameter int DIV = TICK_CYCLES
)(
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  // Tick link
  pusc_seq_if.tmr   t
);

  localparam int CW = $clog2(DIV + 1);

  if (DIV < 1)
  begin : g_chk
    $error("pusc_tick: DIV must be at least 1");
  end

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          last;

  assign last   = (cnt_r == CW'(DIV - 1));
  assign t.tick = t.tick_en && last;

  // Counter restarts whenever disabled so every hold starts on a full period
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (!t.tick_en || last)
      cnt_nxt = '0;
    else
      cnt_nxt = cnt_r + CW'(1);
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

endmodule
`default_nettype wire

/* File: hw/pusc_strap_seq.sv */
// Sequencer: one sampling instant after reset, then the strap hold interval
`default_nettype none
module pusc_strap_seq
  import pusc_pkg::*;
#(
  parameter int HOLD = HOLD_TICKS
)(
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  // Sequencing link
  pusc_seq_if.seq   s
);

  localparam int CW = $clog2(HOLD + 1);

  if (HOLD < 1)
  begin : g_chk
    $error("pusc_strap_seq: HOLD must be at least 1");
  end

  typedef enum logic [1:0] {ST_SAMPLE, ST_HOLD, ST_FREE} pusc_seq_st_t;

  pusc_seq_st_t  st_r;
  pusc_seq_st_t  st_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  assign s.sample  = (st_r == ST_SAMPLE);
  assign s.holding = (st_r != ST_FREE);
  assign s.tick_en = (st_r == ST_HOLD);

  // Next state: sample on the first cycle out of reset, count ticks, release
  always_comb
  begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      ST_SAMPLE:
        st_nxt = ST_HOLD;
      ST_HOLD:
        if (s.tick)
        begin
          if (cnt_r == CW'(HOLD - 1))
            st_nxt = ST_FREE;
          else
            cnt_nxt = cnt_r + CW'(1);
        end
      ST_FREE:
        st_nxt = ST_FREE;
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      st_r  <= ST_SAMPLE;
      cnt_r <= '0;
    end
    else
    begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Sampling happens once per reset
  chk_sample_once: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    s.sample |=> !s.sample [*8])
    else $error("strap sample repeated");

  // Release exactly after the last hold tick
  chk_hold_end: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (st_r == ST_HOLD && s.tick && cnt_r == CW'(HOLD - 1)) |=> !s.holding)
    else $error("strap hold did not end on last tick");

endmodule
`default_nettype wire

/* File: hw/pusc_top.sv */
// Top: power-up strap capture, reference input configuration and clock defaults
`default_nettype none
module pusc_top
  import pusc_pkg::*;
#(
  parameter int HOLD_TICKS_P = HOLD_TICKS,
  parameter int TICK_DIV_P   = TICK_CYCLES
)(
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              nrst_i,
  // Strap pins
  input  wire logic [GPIO_W-1:0] gpio_i,
  // Register port
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [7:0]        reg_wdata_i,
  output logic      [7:0]        reg_rdata_o,
  // Reference input mode
  output logic                   ref_diff_o,
  // Strap results
  output logic                   strap_active_o,
  output logic      [1:0]        mclk_code_o,
  output logic                   mclk_valid_o,
  output logic      [KHZ_W-1:0]  refmon_base_khz_o,
  output logic      [2:0]        strap_aux_o,
  // Output clock defaults
  output logic                   oclk0_en_o,
  output logic                   oclk1_en_o,
  output logic      [KHZ_W-1:0]  oclk0_khz_o,
  output logic      [KHZ_W-1:0]  oclk1_khz_o
);

  // A zero-length hold or divider would free the strap pins before they settle
  if (HOLD_TICKS_P < 1)
  begin : g_hold_chk
    $error("pusc_top: HOLD_TICKS_P must be at least 1");
  end

  if (TICK_DIV_P < 1)
  begin : g_div_chk
    $error("pusc_top: TICK_DIV_P must be at least 1");
  end

  // Sequencing between the sampler, the hold timer and this level
  // The divider only runs during the hold, so it is idle once straps are freed
  pusc_seq_if seq ();

  pusc_strap_seq #(
    .HOLD (HOLD_TICKS_P)
  ) u_seq (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .s      (seq)
  );

  pusc_tick #(
    .DIV (TICK_DIV_P)
  ) u_tick (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .t      (seq)
  );

  // ---------------------------------------------------------------
  // Register group
  // ---------------------------------------------------------------
  logic [7:0] ref_cfg_r;
  logic [7:0] ref_cfg_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       hit;

  // Address decode shared by the register logic and its checks
  function automatic logic pusc_ref_cfg_sel(input logic [7:0] a);
    pusc_ref_cfg_sel = (a == REF_CFG_OFF);
  endfunction

  assign hit = pusc_ref_cfg_sel(reg_addr_i);

  // Write stores the whole byte; unmapped reads answer zero
  always_comb
  begin
    ref_cfg_nxt = ref_cfg_r;
    rdata_nxt   = rdata_r;
    if (reg_wr_i && hit)
      ref_cfg_nxt = reg_wdata_i;
    if (reg_rd_i)
      rdata_nxt = hit ? ref_cfg_r : 8'h00;
  end

  // Reset leaves the reference single-ended
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      ref_cfg_r <= REF_CFG_RST;
      rdata_r   <= 8'h00;
    end
    else
    begin
      ref_cfg_r <= ref_cfg_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign ref_diff_o  = ref_cfg_r[REF_DIFF_BIT];

  // ---------------------------------------------------------------
  // Strap configuration group
  // ---------------------------------------------------------------
  logic [1:0]       mcode_r;
  logic [1:0]       mcode_nxt;
  logic             mvalid_r;
  logic             mvalid_nxt;
  logic [KHZ_W-1:0] mkhz_r;
  logic [KHZ_W-1:0] mkhz_nxt;
  logic [2:0]       aux_r;
  logic [2:0]       aux_nxt;
  logic             oen0_r;
  logic             oen0_nxt;
  logic             oen1_r;
  logic             oen1_nxt;
  logic             active_r;
  logic             active_nxt;

  // Pins are looked at only in the sample cycle, so late glitches are harmless
  // Reserved select codes are kept as captured; the valid flag stays low for them
  always_comb
  begin
    mcode_nxt  = mcode_r;
    mvalid_nxt = mvalid_r;
    mkhz_nxt   = mkhz_r;
    aux_nxt    = aux_r;
    oen0_nxt   = oen0_r;
    oen1_nxt   = oen1_r;
    active_nxt = seq.holding;
    if (seq.sample)
    begin
      mcode_nxt  = gpio_i[MSEL_LSB +: 2];
      mvalid_nxt = gpio_i[MSEL_LSB + 1];
      mkhz_nxt   = pusc_mclk_khz(gpio_i[MSEL_LSB +: 2]);
      aux_nxt    = gpio_i[AUX_LSB +: 3];
      oen0_nxt   = gpio_i[OCLK0_BIT];
      oen1_nxt   = gpio_i[OCLK1_BIT];
    end
  end

  // Defaults hold until the sample: clock one on, clock zero off
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      mcode_r  <= MSEL_RST;
      mvalid_r <= 1'b0;
      mkhz_r   <= '0;
      aux_r    <= 3'h0;
      oen0_r   <= OCLK0_EN_RST;
      oen1_r   <= OCLK1_EN_RST;
      active_r <= 1'b1;
    end
    else
    begin
      mcode_r  <= mcode_nxt;
      mvalid_r <= mvalid_nxt;
      mkhz_r   <= mkhz_nxt;
      aux_r    <= aux_nxt;
      oen0_r   <= oen0_nxt;
      oen1_r   <= oen1_nxt;
      active_r <= active_nxt;
    end
  end

  // Output clock rates are fixed defaults; the synthesizer reads them when enabled
  logic [KHZ_W-1:0] okhz0_r;
  logic [KHZ_W-1:0] okhz0_nxt;
  logic [KHZ_W-1:0] okhz1_r;
  logic [KHZ_W-1:0] okhz1_nxt;

  // Rates are constants; kept in flops so every output leaves a register
  always_comb
  begin
    okhz0_nxt = OCLK0_KHZ;
    okhz1_nxt = OCLK1_KHZ;
  end

  // No reset needed: the value is the same before and after reset
  always_ff @(posedge mclk_i)
  begin
    okhz0_r <= okhz0_nxt;
    okhz1_r <= okhz1_nxt;
  end

  assign mclk_code_o       = mcode_r;
  assign mclk_valid_o      = mvalid_r;
  assign refmon_base_khz_o = mkhz_r;
  assign strap_aux_o       = aux_r;
  assign oclk0_en_o        = oen0_r;
  assign oclk1_en_o        = oen1_r;
  assign oclk0_khz_o       = okhz0_r;
  assign oclk1_khz_o       = okhz1_r;
  assign strap_active_o    = active_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_ref_rst_single: assert property (@(posedge mclk_i)
    !nrst_i |=> !ref_diff_o && reg_rdata_o == 8'h00)
    else $error("reference not single-ended after reset");

  chk_ref_write_mode: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (reg_wr_i && reg_addr_i == REF_CFG_OFF) |=> ref_diff_o == $past(reg_wdata_i[REF_DIFF_BIT]))
    else $error("reference mode not taken from write");

  chk_strap_mclk_take: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    seq.sample |=> mclk_code_o == $past(gpio_i[1:0]) && strap_aux_o == $past(gpio_i[5:3]))
    else $error("strap levels not captured at sample");

  chk_mclk_decode: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !seq.sample |-> mclk_valid_o == mclk_code_o[1]
                    && refmon_base_khz_o == pusc_mclk_khz(mclk_code_o))
    else $error("master clock code decoded wrongly");

  chk_strap_release: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !strap_active_o |=> !strap_active_o)
    else $error("strap pins reclaimed after release");

  chk_oclk_strap_en: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    seq.sample |=> oclk0_en_o == $past(gpio_i[OCLK0_BIT])
                   && oclk1_en_o == $past(gpio_i[OCLK1_BIT]))
    else $error("output clock enable straps not captured");

  chk_oclk_rates: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !seq.sample |-> oclk0_khz_o == OCLK0_KHZ && oclk1_khz_o == OCLK1_KHZ)
    else $error("output clock default rates wrong");

  chk_cfg_frozen: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !seq.sample |=> $stable(mclk_code_o) && $stable(oclk0_en_o) && $stable(oclk1_en_o))
    else $error("strap configuration changed after sample");

  chk_reset_dflt: assert property (@(posedge mclk_i)
    !nrst_i |=> !oclk0_en_o && oclk1_en_o && strap_active_o && !mclk_valid_o)
    else $error("defaults not applied by reset");

  chk_read_back: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (reg_rd_i && pusc_ref_cfg_sel(reg_addr_i)) |=> reg_rdata_o == $past(ref_cfg_r))
    else $error("register read did not return stored value");

  chk_read_unmapped: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (reg_rd_i && !pusc_ref_cfg_sel(reg_addr_i)) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read returned data");

  chk_rdata_hold: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");

  chk_write_ignored: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (reg_wr_i && !pusc_ref_cfg_sel(reg_addr_i)) |=> $stable(ref_diff_o))
    else $error("unmapped write changed reference mode");

  chk_strap_window: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    seq.sample |=> strap_active_o)
    else $error("strap pins released too early");

  chk_aux_frozen: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    !seq.sample |=> $stable(strap_aux_o) && $stable(refmon_base_khz_o))
    else $error("aux straps or monitor base changed after sample");

  chk_mclk_range: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    mclk_valid_o |-> refmon_base_khz_o == MCLK_20_KHZ || refmon_base_khz_o == MCLK_24_KHZ)
    else $error("valid master clock code with unknown rate");

  cov_diff_sel: cover property (@(posedge mclk_i) disable iff (!nrst_i)
    reg_wr_i && reg_addr_i == REF_CFG_OFF && reg_wdata_i[REF_DIFF_BIT]);

  cov_sample_24m: cover property (@(posedge mclk_i) disable iff (!nrst_i)
    seq.sample && gpio_i[1:0] == MSEL_24M);

  cov_release: cover property (@(posedge mclk_i) disable iff (!nrst_i)
    $fell(strap_active_o));

  cov_sample_20m: cover property (@(posedge mclk_i) disable iff (!nrst_i)
    seq.sample && gpio_i[1:0] == MSEL_20M);

  cov_oclk1_off: cover property (@(posedge mclk_i) disable iff (!nrst_i)
    seq.sample && !gpio_i[OCLK1_BIT]);

endmodule
`default_nettype wire

/* File: verif/pusc_board_model.sv */
// Board model: power reset pulse and strap drivers seen by the strap block
`default_nettype none
module pusc_board_model
  import pusc_pkg::*;
#(
  parameter int RST_CYC  = 8,
  parameter int HOLD_CYC = 20
)(
  // Clock and request
  input  wire logic              mclk_i,
  input  wire logic              start_i,
  input  wire logic [GPIO_W-1:0] strap_i,
  // Board pins
  output logic                   nrst_o,
  output logic      [GPIO_W-1:0] gpio_o
);
  int   cnt;
  int   phase;
  logic go;

  // Pins move 1 ns after an edge; the request is taken at the edge itself
  initial
  begin
    nrst_o = 1'b0;
    gpio_o = '0;
    cnt    = 1;  // Reset is already low at time zero: opening pulse lasts RST_CYC edges
    phase  = 0;
    forever
    begin
      @(posedge mclk_i);
      go = start_i;
      #1;
      if (go)
      begin
        phase = 0;
        cnt   = 0;
      end
      // Reset low shortened from milliseconds to a few cycles
      if (phase == 0)
      begin
        nrst_o = 1'b0;
        gpio_o = strap_i;
        cnt++;
        if (cnt >= RST_CYC)
          phase = 1;
      end
      // Straps held steady past the design's hold interval
      else if (phase == 1)
      begin
        nrst_o = 1'b1;
        cnt++;
        if (cnt > RST_CYC + HOLD_CYC)
          phase = 2;
      end
      // Released pins: toggle every cycle between the inverse and the old level
      else
        gpio_o = ~gpio_o;
    end
  end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Testbench: reset defaults, register, strap capture and hold interval
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pusc_pkg::*;

  localparam int HOLD_P = 4;
  localparam int DIV_P  = 3;
  localparam int FALL_N = 1 + HOLD_P * DIV_P;
  localparam int LIMIT  = 3000;

  logic              mclk_i;
  logic              nrst;
  logic [GPIO_W-1:0] gpio;
  logic [GPIO_W-1:0] strap;
  logic              start;
  logic [7:0]        addr;
  logic              wr;
  logic              rd;
  logic [7:0]        wdata;
  logic [7:0]        rdata;
  logic              rdiff;
  logic              sact;
  logic [1:0]        code;
  logic              valid;
  logic [KHZ_W-1:0]  base;
  logic [2:0]        aux;
  logic              en0;
  logic              en1;
  logic [KHZ_W-1:0]  khz0;
  logic [KHZ_W-1:0]  khz1;
  int                fail_count;
  int                total_checks;
  int                cycles;

  pusc_top #(.HOLD_TICKS_P(HOLD_P), .TICK_DIV_P(DIV_P)) i_pusc_top (
    .mclk_i(mclk_i), .nrst_i(nrst), .gpio_i(gpio), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .ref_diff_o(rdiff),
    .strap_active_o(sact), .mclk_code_o(code), .mclk_valid_o(valid),
    .refmon_base_khz_o(base), .strap_aux_o(aux), .oclk0_en_o(en0), .oclk1_en_o(en1),
    .oclk0_khz_o(khz0), .oclk1_khz_o(khz1));

  pusc_board_model i_pusc_board_model (
    .mclk_i(mclk_i), .start_i(start), .strap_i(strap), .nrst_o(nrst), .gpio_o(gpio));

  // Free-running 250 MHz clock
  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  // Hang guard: the whole run needs well under LIMIT cycles
  always @(posedge mclk_i)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (fail_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_val(input logic [16:0] got, input logic [16:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Inputs always move 1 ns after the rising edge
  task automatic step();
    @(posedge mclk_i);
    #1;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    step();
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    step();
    wr = 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [16:0] d);
    step();
    addr = a;
    rd   = 1'b1;
    step();
    rd = 1'b0;
    d  = {9'h000, rdata};
  endtask

  // New reset pulse with the given straps; returns at the sampling edge
  task automatic run_reset(input logic [GPIO_W-1:0] s);
    strap = s;
    step();
    start = 1'b1;
    step();
    start = 1'b0;
    @(posedge mclk_i);
    while (nrst !== 1'b1)
      @(posedge mclk_i);
  endtask

  task automatic check_caps(input logic [GPIO_W-1:0] s, input logic [16:0] f);
    check_val({15'h0000, code}, {15'h0000, s[1:0]});
    check_bit(valid, s[1]);
    check_val(base, f);
    check_val({14'h0000, aux}, {14'h0000, s[5:3]});
    check_bit(en0, s[2]);
    check_bit(en1, s[6]);
    check_val(khz0, 17'h061a8);
    check_val(khz1, 17'h1e848);
  endtask

  task automatic test_defaults();
    repeat (4) step();
    check_bit(sact, 1'b1);
    check_bit(rdiff, 1'b0);
    check_bit(valid, 1'b0);
    check_bit(en0, 1'b0);
    check_bit(en1, 1'b1);
    while (nrst !== 1'b1)
      step();
  endtask

  task automatic test_register();
    logic [16:0] d;
    reg_read(8'h0a, d);
    check_val(d, 17'h00000);
    reg_write(8'h0a, 8'ha5);
    check_bit(rdiff, 1'b1);
    reg_read(8'h0a, d);
    check_val(d, 17'h000a5);
    reg_write(8'h0b, 8'h00);
    check_bit(rdiff, 1'b1);
    reg_read(8'h0b, d);
    check_val(d, 17'h00000);
    reg_write(8'h0a, 8'h5a);
    check_bit(rdiff, 1'b0);
    reg_write(8'h0a, 8'h01);
    run_reset(7'h42);
    step();
    check_bit(rdiff, 1'b0);
    reg_read(8'h0a, d);
    check_val(d, 17'h00000);
  endtask

  // Capture, hold interval length, and immunity to later pin activity
  task automatic test_straps(input logic [GPIO_W-1:0] s);
    logic [16:0] f;
    int          n;
    f = (s[1:0] == 2'h2) ? 17'h04e20 : (s[1:0] == 2'h3) ? 17'h06000 : 17'h00000;
    run_reset(s);
    step();
    check_caps(s, f);
    n = 1;
    while (sact === 1'b1 && n < 40)
    begin
      step();
      n++;
    end
    check_bit(n == FALL_N, 1'b1);
    repeat (12) step();
    check_caps(s, f);
  endtask

  // Main sequence
  initial
  begin
    fail_count   = 0;
    total_checks = 0;
    cycles       = 0;
    addr         = 8'h00;
    wr           = 1'b0;
    rd           = 1'b0;
    wdata        = 8'h00;
    start        = 1'b0;
    strap        = 7'h02;
    test_defaults();
    test_register();
    test_straps(7'h02);
    test_straps(7'h7f);
    test_straps(7'h29);
    test_straps(7'h44);
    report_and_stop();
  end
endmodule
`default_nettype wire
